/* mas_scale.sv */
// Purpose: motor/aux input conditioning, auto range, linear scaling, motor output
// Assumes: 25 MHz ref_clk, sync active-high rst, samples come from a front end
// Notes:   one shared arithmetic path walks the eight channels per period
// Operation
// RQ1 - separate scale factors per channel and for motor output, clamped 0.0001..99999.9999; code refuses out-of-range writes, keeping the old value
// RQ2 - revolution scale used in linear scaling if analog, pulse-count equation if pulse
// RQ3 - torque scale used in linear scaling if analog, pulse-rating equation if pulse
// RQ4 - motor output is 2pi/60 times speed times torque times its scale
// RQ5 - each channel stores an eight character printable unit label
// RQ6 - each channel selects analog or pulse, which picks the settings used
// RQ7 - auto range picks among 20, 10, 5, 2 and 1 volt
// RQ8 - step up when level exceeds 110 percent of range
// RQ9 - step up when peak exceeds 150 percent of range
// RQ10 - step down when level under 30 percent and peak under 125 percent lower range
// RQ11 - auto off holds the user fixed range
// RQ12 - slope 1m..1M motor, +-1M aux, nonzero; offset +-1M
// RQ13 - value is scale times slope times input plus offset minus null
// RQ14 - linear scaling for analog and for aux pulse inputs
// RQ15 - execute derives slope and offset from two points
// RQ16 - analog line filter off, 100 Hz, 500 Hz, 1 kHz
// RQ17 - pulse noise filter off, 10 kHz, 100 kHz, 1 MHz
// RQ18 - measurement period from crossings of the chosen sync source
// RQ19 - no sync source: update interval, or timeout in auto update
// RQ20 - pulse channels reuse the previous value when no period fits
// RQ21 - operator should match the motor sync source to the power one
// RQ22 - digital filter averaging ignores the sync source
// RQ23 - aux mode does not apply pole or sync-speed source settings
// RQ24 - pulses per revolution 1..9999, speed is scale times (ppm/N - null)
// RQ25 - mode assigns channels A..H to torque, speed or aux
// RQ26 - range changes only at measurement boundaries
`timescale 1ns/1ps
`include "mas_defines.svh"
`default_nettype none
module mas_scale
	import mas_pkg::*;
#(
	parameter int TIMEOUT_CYC = `MAS_TIMEOUT_MS * `MAS_CLK_KHZ
)(
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [31:0]           reg_rdata,
	input  wire mas_sample_t      sample [8],
	input  wire logic             update_tick,
	input  wire logic             elem_cross,
	input  wire logic             ext_clk_in,
	input  wire logic             index_pulse_first_motor,
	input  wire logic             index_pulse_third_motor,
	output logic [2:0]            range_sel [8],
	output logic [1:0]            line_filt_sel [8],
	output logic [1:0]            pulse_filt_sel [8],
	output mas_func_t             chan_func [8],
	output logic [6:0]            pole_eff,
	output logic [3:0]            freq_src_eff,
	output logic signed [31:0]    meas_value [8],
	output logic signed [31:0]    mechanical_output,
	output logic                  meas_done
);
	// ----------------------------------------
	// configuration state
	// ----------------------------------------
	mas_mode_t          motor_input_group_r;
	logic               method_dig_r;
	logic               auto_upd_r;
	mas_sync_t          sync_sel_r;
	logic [2:0]         chsel_r;
	mas_chcfg_t         cfg_r [8];
	logic signed [31:0] scale_r [8];
	logic signed [31:0] slope_r [8];
	logic signed [31:0] offset_r [8];
	logic signed [31:0] null_r [8];
	logic [13:0]        pulsen_r [8];
	logic [31:0]        unit_r [16];
	logic signed [31:0] first_point_voltage_r, first_point_value_r;
	logic signed [31:0] second_point_voltage_r, second_point_value_r;
	logic signed [31:0] mscale_r;
	logic [6:0]         pole_r;
	logic [3:0]         fsrc_r;
	logic               calc_err_r;
	logic [2:0]         range_r [8];
	logic signed [31:0] xhold_r [8];
	logic signed [31:0] result_r [8];
	logic signed [31:0] mech_r;
	mas_state_t         state_r;
	logic [2:0]         ch_r;
	logic               done_r;

	// ----------------------------------------
	// write decode and value checks
	// ----------------------------------------
	wire aux_mode = (motor_input_group_r == MAS_AUX);
	wire signed [31:0] wd = reg_wdata;
	wire scale_ok = (wd >= `MAS_SCALE_MIN) && (wd <= `MAS_SCALE_MAX);
	wire signed [31:0] slope_lo = aux_mode ? -`MAS_MEG_M : `MAS_SLOPE_MINM;
	// a zero slope would collapse every reading, so it is refused outright
	wire slope_ok = (wd >= slope_lo) && (wd <= `MAS_MEG_M) && (wd != 32'sd0);
	wire offset_ok = (wd >= -`MAS_MEG_M) && (wd <= `MAS_MEG_M);
	wire pn_ok = (reg_wdata[13:0] >= `MAS_PN_MIN) && (reg_wdata[13:0] <= `MAS_PN_MAX)
		&& (reg_wdata[31:14] == 18'h0);
	wire wr_ctrl = reg_wr && (reg_addr == `MAS_A_CTRL);
	wire wr_calc = reg_wr && (reg_addr == `MAS_A_CALC);

	// clamp each label byte to the printable set, others become a space
	function automatic logic [31:0] mas_printable(input logic [31:0] w);
		logic [31:0] o;
		o = w;
		for (int i = 0; i < 4; i++)
		begin
			if (w[i*8 +: 8] < `MAS_CHAR_LO || w[i*8 +: 8] > `MAS_CHAR_HI)
				o[i*8 +: 8] = `MAS_CHAR_SP;
		end
		return o;
	endfunction

	// ----------------------------------------
	// two point slope and offset
	// ----------------------------------------
	wire signed [63:0] dx = 64'(second_point_voltage_r) - 64'(first_point_voltage_r);
	wire signed [63:0] dy = 64'(second_point_value_r) - 64'(first_point_value_r);
	wire signed [63:0] tp_slope = (dx == 64'sd0) ? 64'sd0 : (dy * 64'(`MAS_MILLI)) / dx;
	wire signed [63:0] tp_off = 64'(first_point_value_r) * 64'(`MAS_MILLI)
		- tp_slope * 64'(first_point_voltage_r);
	wire tp_ok = (dx != 64'sd0) && (tp_slope != 64'sd0)
		&& (tp_slope >= 64'(slope_lo)) && (tp_slope <= 64'(`MAS_MEG_M))
		&& (tp_off >= -64'(`MAS_MEG_M)) && (tp_off <= 64'(`MAS_MEG_M));

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			motor_input_group_r <= MAS_SINGLE_PULSE;
			method_dig_r <= 1'b0;
			auto_upd_r <= 1'b0;
			sync_sel_r <= MAS_SYNC_NONE;
			chsel_r <= 3'd0;
			mscale_r <= `MAS_SCALE_ONE;
			pole_r <= `MAS_POLE_RST;
			fsrc_r <= 4'h0;
			calc_err_r <= 1'b0;
			first_point_voltage_r <= 32'sd0;
			first_point_value_r <= 32'sd0;
			second_point_voltage_r <= 32'sd0;
			second_point_value_r <= 32'sd0;
			for (int c = 0; c < 8; c++)
			begin
				cfg_r[c] <= '0;
				scale_r[c] <= `MAS_SCALE_ONE;
				slope_r[c] <= `MAS_MILLI;
				offset_r[c] <= 32'sd0;
				null_r[c] <= 32'sd0;
				pulsen_r[c] <= `MAS_PN_RST;
				unit_r[2*c] <= {4{`MAS_CHAR_SP}};
				unit_r[2*c+1] <= {4{`MAS_CHAR_SP}};
			end
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				`MAS_A_CTRL:
				begin
					motor_input_group_r <= mas_mode_t'(reg_wdata[1:0]);
					method_dig_r <= reg_wdata[2];
					auto_upd_r <= reg_wdata[3];
					sync_sel_r <= mas_sync_t'(reg_wdata[6:4]);
				end
				`MAS_A_CHSEL:  chsel_r <= reg_wdata[2:0];
				`MAS_A_CHCFG:  cfg_r[chsel_r] <= mas_chcfg_t'(reg_wdata[8:0]);   // [RQ6] [RQ16] [RQ17]
				`MAS_A_SCALE:  if (scale_ok) scale_r[chsel_r] <= wd;            // [RQ1]
				`MAS_A_SLOPE:  if (slope_ok) slope_r[chsel_r] <= wd;            // [RQ12]
				`MAS_A_OFFSET: if (offset_ok) offset_r[chsel_r] <= wd;          // [RQ12]
				`MAS_A_NULL:   null_r[chsel_r] <= wd;
				`MAS_A_PULSEN: if (pn_ok) pulsen_r[chsel_r] <= reg_wdata[13:0]; // [RQ24]
				`MAS_A_UNITLO: unit_r[{chsel_r, 1'b0}] <= mas_printable(reg_wdata); // [RQ5]
				`MAS_A_UNITHI: unit_r[{chsel_r, 1'b1}] <= mas_printable(reg_wdata); // [RQ5]
				`MAS_A_P1X:    first_point_voltage_r <= wd;
				`MAS_A_P1Y:    first_point_value_r <= wd;
				`MAS_A_P2X:    second_point_voltage_r <= wd;
				`MAS_A_P2Y:    second_point_value_r <= wd;
				`MAS_A_CALC:
				begin
					calc_err_r <= !tp_ok;
					if (tp_ok)
					begin
						slope_r[chsel_r] <= 32'(tp_slope);  // [RQ15]
						offset_r[chsel_r] <= 32'(tp_off);   // [RQ15]
					end
				end
				`MAS_A_MSCALE: if (scale_ok) mscale_r <= wd;                    // [RQ1]
				`MAS_A_POLE:
				begin
					pole_r <= reg_wdata[6:0];
					fsrc_r <= reg_wdata[11:8];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// measurement period boundary
	// ----------------------------------------
	logic ext_d_r, z1_d_r, z3_d_r;
	logic [31:0] to_cnt_r;
	wire to_tick = (to_cnt_r >= 32'(TIMEOUT_CYC - 1));
	logic sync_cross;
	always_comb
	begin
		case (sync_sel_r)
			MAS_SYNC_ELEM: sync_cross = elem_cross;
			MAS_SYNC_EXT:  sync_cross = ext_clk_in && !ext_d_r;
			MAS_SYNC_Z1:   sync_cross = index_pulse_first_motor && !z1_d_r;
			MAS_SYNC_Z3:   sync_cross = index_pulse_third_motor && !z3_d_r;
			default:       sync_cross = 1'b0;
		endcase
	end
	// digital filter ignores the sync choice; none falls back to interval or timeout
	wire period_end = method_dig_r ? update_tick                            // [RQ22]
		: (sync_sel_r == MAS_SYNC_NONE) ? (auto_upd_r ? to_tick : update_tick) // [RQ19]
		: sync_cross;                                                       // [RQ18]
	wire boundary = period_end && (state_r == MAS_IDLE);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ext_d_r <= 1'b0;
			z1_d_r <= 1'b0;
			z3_d_r <= 1'b0;
			to_cnt_r <= 32'd0;
		end
		else
		begin
			ext_d_r <= ext_clk_in;
			z1_d_r <= index_pulse_first_motor;
			z3_d_r <= index_pulse_third_motor;
			to_cnt_r <= (to_tick || period_end) ? 32'd0 : to_cnt_r + 32'd1;
		end
	end

	// ----------------------------------------
	// auto range, one decision per channel per boundary
	// ----------------------------------------
	function automatic logic [31:0] mas_rng_mv(input logic [2:0] i);
		case (i)
			3'd0:    return 32'd20000;
			3'd1:    return 32'd10000;
			3'd2:    return 32'd5000;
			3'd3:    return 32'd2000;
			default: return 32'd1000;
		endcase
	endfunction

	logic [2:0] range_nxt [8];
	always_comb
	begin
		for (int c = 0; c < 8; c++)
		begin
			logic [31:0] lv, pk, rg, lo;
			lv = 32'(sample[c].level_mv) * `MAS_PCT_ONE;
			pk = 32'(sample[c].peak_mv) * `MAS_PCT_ONE;
			rg = mas_rng_mv(range_r[c]);
			lo = mas_rng_mv(range_r[c] + 3'd1);
			range_nxt[c] = range_r[c];
			if (!cfg_r[c].autorange)
				range_nxt[c] = (cfg_r[c].fixrange > `MAS_RNG_MAX) ? `MAS_RNG_MAX
					: cfg_r[c].fixrange;                                      // [RQ11]
			else if ((lv > rg * `MAS_PCT_UP || pk > rg * `MAS_PCT_PEAK)
				&& range_r[c] != 3'd0)
				range_nxt[c] = range_r[c] - 3'd1;                             // [RQ8] [RQ9]
			else if (lv < rg * `MAS_PCT_DOWN && pk < lo * `MAS_PCT_LOWPK
				&& range_r[c] < `MAS_RNG_MAX)
				range_nxt[c] = range_r[c] + 3'd1;                             // [RQ10]
		end
	end

	// ranges only move on a boundary so no period mixes two gains
	always_ff @(posedge ref_clk)
	begin
		for (int c = 0; c < 8; c++)
		begin
			if (rst)
				range_r[c] <= 3'd0;
			else if (boundary && !cfg_r[c].pulse)
				range_r[c] <= range_nxt[c];                                   // [RQ7] [RQ26]
		end
	end

	// ----------------------------------------
	// channel roles and filter selects
	// ----------------------------------------
	always_comb
	begin
		for (int c = 0; c < 8; c++)
		begin
			case (motor_input_group_r)                                        // [RQ25]
				MAS_AUX:           chan_func[c] = MAS_FN_AUX;
				MAS_DOUBLE:        chan_func[c] = c[0] ? MAS_FN_SPEED : MAS_FN_TORQUE;
				MAS_SINGLE_ANALOG: chan_func[c] = (c[1:0] == 2'd0) ? MAS_FN_TORQUE
					: (c[1:0] == 2'd2) ? MAS_FN_SPEED : MAS_FN_UNUSED;
				default:           chan_func[c] = (c[1:0] == 2'd0) ? MAS_FN_TORQUE
					: MAS_FN_SPEED;
			endcase
			range_sel[c] = range_r[c];
			line_filt_sel[c] = cfg_r[c].pulse ? 2'd0 : cfg_r[c].lfilt;       // [RQ16]
			pulse_filt_sel[c] = cfg_r[c].pulse ? cfg_r[c].pfilt : 2'd0;      // [RQ17]
			meas_value[c] = result_r[c];
		end
	end
	assign pole_eff = aux_mode ? 7'd0 : pole_r;                              // [RQ23]
	assign freq_src_eff = aux_mode ? 4'h0 : fsrc_r;                          // [RQ23]

	// ----------------------------------------
	// shared scaling path, one channel per cycle
	// ----------------------------------------
	mas_chcfg_t cc;
	assign cc = cfg_r[ch_r];
	// a pulse channel with no whole period keeps the last input
	wire signed [63:0] xin = 64'((cc.pulse && !sample[ch_r].x_valid)
		? xhold_r[ch_r] : sample[ch_r].x);                                   // [RQ20]
	wire use_lin = !cc.pulse || aux_mode;                                    // [RQ14]
	wire is_speed = (chan_func[ch_r] == MAS_FN_SPEED);
	wire signed [63:0] lin = (64'(slope_r[ch_r]) * xin) / 64'(`MAS_MILLI)
		+ 64'(offset_r[ch_r]) - 64'(null_r[ch_r]);                         // [RQ13]
	// signed divisor so a negative pulse rate is not divided as unsigned
	wire signed [63:0] ppr = xin / $signed(64'(pulsen_r[ch_r])) - 64'(null_r[ch_r]); // [RQ24]
	wire signed [63:0] raw = use_lin ? lin : (is_speed ? ppr              // [RQ2]
		: xin - 64'(null_r[ch_r]));                                         // [RQ3]
	wire signed [63:0] scaled = (raw * 64'(scale_r[ch_r])) / 64'(`MAS_SCALE_ONE);
	// motor 1 output from its torque and speed channels
	wire signed [31:0] spd = (motor_input_group_r == MAS_SINGLE_ANALOG) ? result_r[2]
		: result_r[1];
	wire signed [95:0] pm = (96'(spd) * 96'(result_r[0]) * `MAS_TWO_PI_60)
		>>> `MAS_K_SHIFT;
	wire signed [95:0] pm_s = (pm * 96'(mscale_r)) / 96'(`MAS_SCALE_ONE);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_r <= MAS_IDLE;
			ch_r <= 3'd0;
			done_r <= 1'b0;
			mech_r <= 32'sd0;
			for (int c = 0; c < 8; c++)
			begin
				xhold_r[c] <= 32'sd0;
				result_r[c] <= 32'sd0;
			end
		end
		else
		begin
			done_r <= 1'b0;
			case (state_r)
				MAS_IDLE:
				begin
					ch_r <= 3'd0;
					if (boundary)
						state_r <= MAS_CALC;
				end
				MAS_CALC:
				begin
					result_r[ch_r] <= 32'(scaled);                              // [RQ1] [RQ13]
					xhold_r[ch_r] <= 32'(xin);
					ch_r <= ch_r + 3'd1;
					if (ch_r == 3'd7)
						state_r <= MAS_MECH;
				end
				MAS_MECH:
				begin
					if (!aux_mode)
						mech_r <= 32'(pm_s);                                    // [RQ4]
					done_r <= 1'b1;
					state_r <= MAS_IDLE;
				end
				default: state_r <= MAS_IDLE;
			endcase
		end
	end
	assign mechanical_output = mech_r;
	assign meas_done = done_r;

	// ----------------------------------------
	// register reads, data one cycle after the strobe
	// ----------------------------------------
	logic [31:0] rd_mux;
	always_comb
	begin
		case (reg_addr)
			`MAS_A_CTRL:   rd_mux = {25'h0, sync_sel_r, auto_upd_r, method_dig_r,
				motor_input_group_r};
			`MAS_A_CHSEL:  rd_mux = {29'h0, chsel_r};
			`MAS_A_CHCFG:  rd_mux = {23'h0, cfg_r[chsel_r]};
			`MAS_A_SCALE:  rd_mux = scale_r[chsel_r];
			`MAS_A_SLOPE:  rd_mux = slope_r[chsel_r];
			`MAS_A_OFFSET: rd_mux = offset_r[chsel_r];
			`MAS_A_NULL:   rd_mux = null_r[chsel_r];
			`MAS_A_PULSEN: rd_mux = {18'h0, pulsen_r[chsel_r]};
			`MAS_A_UNITLO: rd_mux = unit_r[{chsel_r, 1'b0}];
			`MAS_A_UNITHI: rd_mux = unit_r[{chsel_r, 1'b1}];
			`MAS_A_P1X:    rd_mux = first_point_voltage_r;
			`MAS_A_P1Y:    rd_mux = first_point_value_r;
			`MAS_A_P2X:    rd_mux = second_point_voltage_r;
			`MAS_A_P2Y:    rd_mux = second_point_value_r;
			`MAS_A_MSCALE: rd_mux = mscale_r;
			`MAS_A_POLE:   rd_mux = {20'h0, fsrc_r, 1'b0, pole_r};
			`MAS_A_RESULT: rd_mux = result_r[chsel_r];
			`MAS_A_MECH:   rd_mux = mech_r;
			`MAS_A_STATUS: rd_mux = {26'h0, state_r != MAS_IDLE, calc_err_r, 1'b0,
				range_r[chsel_r]};
			default:       rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire c0_up = !cfg_r[0].pulse && cfg_r[0].autorange && range_r[0] != 3'd0
		&& (32'(sample[0].level_mv) * `MAS_PCT_ONE > mas_rng_mv(range_r[0]) * `MAS_PCT_UP);
	sequence s_up_taken;
		boundary && c0_up;
	endsequence
	property p_scale_range;
		scale_r[chsel_r] >= `MAS_SCALE_MIN && mscale_r <= `MAS_SCALE_MAX;
	endproperty
	a_scale_range: assert property (p_scale_range) else $error("scale out of range"); // [RQ1]
	property p_range_set;
		range_r[0] <= `MAS_RNG_MAX;
	endproperty
	a_range_set: assert property (p_range_set) else $error("range index too big"); // [RQ7]
	property p_range_step;
		s_up_taken |=> range_r[0] == $past(range_r[0]) - 3'd1;
	endproperty
	a_range_step: assert property (p_range_step) else $error("no step up"); // [RQ8]
	property p_range_hold;
		!$stable(range_r[0]) |-> $past(boundary);
	endproperty
	a_range_hold: assert property (p_range_hold) else $error("range moved mid period"); // [RQ26]
	property p_fixed;
		boundary && !cfg_r[0].pulse && !cfg_r[0].autorange && cfg_r[0].fixrange <= 3'd4
			|=> range_r[0] == $past(cfg_r[0].fixrange);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed range not held"); // [RQ11]
	property p_filters;
		cfg_r[3].pulse ? line_filt_sel[3] == 2'd0 : pulse_filt_sel[3] == 2'd0;
	endproperty
	a_filters: assert property (p_filters) else $error("wrong filter active"); // [RQ16]
	property p_digfilt;
		method_dig_r && update_tick && state_r == MAS_IDLE |=> state_r == MAS_CALC;
	endproperty
	a_digfilt: assert property (p_digfilt) else $error("period missed"); // [RQ22]
	property p_aux_pole;
		aux_mode |-> pole_eff == 7'd0 && freq_src_eff == 4'h0;
	endproperty
	a_aux_pole: assert property (p_aux_pole) else $error("pole applied in aux"); // [RQ23]
	property p_pulsen;
		pulsen_r[chsel_r] >= `MAS_PN_MIN && pulsen_r[chsel_r] <= `MAS_PN_MAX;
	endproperty
	a_pulsen: assert property (p_pulsen) else $error("pulse count out of range"); // [RQ24]
	property p_walk;
		boundary |=> (state_r == MAS_CALC) [*8] ##1 (state_r == MAS_MECH) ##1 meas_done;
	endproperty
	a_walk: assert property (p_walk) else $error("scan length wrong"); // [RQ18]
endmodule
`default_nettype wire

/* mas_defines.svh */
// Purpose: constants for the motor/aux input scaling block
// Assumes: fixed point; scale x1e4, slope/offset/null/values x1e3
// Notes:   definitions only
`ifndef MAS_DEFINES_SVH
`define MAS_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MAS_A_CTRL    8'h00
`define MAS_A_CHSEL   8'h04
`define MAS_A_CHCFG   8'h08
`define MAS_A_SCALE   8'h0C
`define MAS_A_SLOPE   8'h10
`define MAS_A_OFFSET  8'h14
`define MAS_A_NULL    8'h18
`define MAS_A_PULSEN  8'h1C
`define MAS_A_UNITLO  8'h20
`define MAS_A_UNITHI  8'h24
`define MAS_A_P1X     8'h28
`define MAS_A_P1Y     8'h2C
`define MAS_A_P2X     8'h30
`define MAS_A_P2Y     8'h34
`define MAS_A_CALC    8'h38
`define MAS_A_MSCALE  8'h3C
`define MAS_A_POLE    8'h40
`define MAS_A_RESULT  8'h44
`define MAS_A_MECH    8'h48
`define MAS_A_STATUS  8'h4C
// ----------------------------------------
// limits and reset values
// ----------------------------------------
`define MAS_SCALE_MIN  32'sd1
`define MAS_SCALE_MAX  32'sd999999999
`define MAS_SCALE_ONE  32'sd10000
`define MAS_MEG_M      32'sd1000000000
`define MAS_SLOPE_MINM 32'sd1
`define MAS_MILLI      32'sd1000
`define MAS_PN_MIN     14'd1
`define MAS_PN_MAX     14'd9999
`define MAS_PN_RST     14'd1
`define MAS_POLE_RST   7'd4
`define MAS_RNG_MAX    3'd4
`define MAS_PCT_UP     32'd110
`define MAS_PCT_PEAK   32'd150
`define MAS_PCT_DOWN   32'd30
`define MAS_PCT_LOWPK  32'd125
`define MAS_PCT_ONE    32'd100
`define MAS_TWO_PI_60  96'sd109807
`define MAS_K_SHIFT    20
`define MAS_CHAR_LO    8'h20
`define MAS_CHAR_HI    8'h7E
`define MAS_CHAR_SP    8'h20
`define MAS_TIMEOUT_MS 32'd1000
`define MAS_CLK_KHZ    32'd25000
`endif

/* mas_pkg.sv */
// Purpose: types for the motor/aux input scaling block
// Assumes: mas_defines.svh holds the numbers
// Notes:   one package for all files
package mas_pkg;
	typedef enum logic [1:0] {MAS_SINGLE_PULSE = 2'd0, MAS_SINGLE_ANALOG = 2'd1,
		MAS_DOUBLE = 2'd2, MAS_AUX = 2'd3} mas_mode_t;
	typedef enum logic [2:0] {MAS_SYNC_NONE = 3'd0, MAS_SYNC_ELEM = 3'd1, MAS_SYNC_EXT = 3'd2,
		MAS_SYNC_Z1 = 3'd3, MAS_SYNC_Z3 = 3'd4} mas_sync_t;
	typedef enum logic [1:0] {MAS_FN_TORQUE = 2'd0, MAS_FN_SPEED = 2'd1, MAS_FN_AUX = 2'd2,
		MAS_FN_UNUSED = 2'd3} mas_func_t;
	typedef enum logic [1:0] {MAS_IDLE = 2'b00, MAS_CALC = 2'b01, MAS_MECH = 2'b11} mas_state_t;
	// per-channel configuration word
	typedef struct packed {
		logic [1:0] pfilt;     // 0 off, 1 10k, 2 100k, 3 1M
		logic [1:0] lfilt;     // 0 off, 1 100, 2 500, 3 1k
		logic [2:0] fixrange;  // 0 20V .. 4 1V
		logic       autorange;
		logic       pulse;     // sense type: 1 pulse, 0 analog
	} mas_chcfg_t;
	// front-end sample for one channel
	typedef struct packed {
		logic [15:0]        level_mv;
		logic [15:0]        peak_mv;
		logic signed [31:0] x;        // milli volts or milli pulses/min or milli Hz
		logic               x_valid;  // pulse: a full pulse period fit
	} mas_sample_t;
endpackage

/* mas_sensor_model.sv */
// Purpose: sensor and torque meter front end seen by mas_scale
// Assumes: one level and peak feed all eight channels
// Notes:   x follows the level in millivolts, every period fits
`timescale 1ns/1ps
`default_nettype none
module mas_sensor_model
	import mas_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic [15:0] lvl,
	input  wire logic [15:0] pk,
	output mas_sample_t      sample [8]
);
	// ------------------------------
	// converter output
	// ------------------------------
	// registered like a real converter, so a new level lands one edge late
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < 8; i++)
			sample[i] <= {lvl, pk, 16'h0000, lvl, 1'b1};
	end
endmodule
`default_nettype wire

/* tb_mas_scale.sv */
// Purpose: self-checking bench for mas_scale
// Assumes: sync none, so update_tick marks each measurement boundary
// Notes:   the wr, rdc and tick tasks align themselves to a rising edge first
`timescale 1ns/1ps
`include "mas_defines.svh"
`default_nettype none
module tb_mas_scale
	import mas_pkg::*;
;
	localparam logic [15:0] T_LVL [5] = '{16'h1388, 16'h1388, 16'h2EE0, 16'h1388, 16'h1388};
	localparam logic [15:0] T_PK  [5] = '{16'h32C8, 16'h1770, 16'h2EE0, 16'h1770, 16'h3E80};
	localparam logic [2:0]  T_RNG [5] = '{3'h0, 3'h1, 3'h0, 3'h1, 3'h0};
	logic ref_clk, rst, reg_wr, reg_rd, update_tick, meas_done;
	logic [7:0]         reg_addr;
	logic [31:0]        reg_wdata, reg_rdata;
	logic [15:0]        lvl, pk;
	mas_sample_t        sample [8];
	logic [2:0]         range_sel [8];
	logic [1:0]         line_filt_sel [8], pulse_filt_sel [8];
	mas_func_t          chan_func [8];
	logic [6:0]         pole_eff;
	logic [3:0]         fsrc;
	logic signed [31:0] meas_value [8], mech;
	int                 fail_count, compares;
	mas_sensor_model sens (.ref_clk(ref_clk), .lvl(lvl), .pk(pk), .sample(sample));
	// short timeout keeps the auto update path cheap in simulation
	mas_scale #(.TIMEOUT_CYC(20)) dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sample(sample), .update_tick(update_tick), .elem_cross(1'b0), .ext_clk_in(1'b0),
		.index_pulse_first_motor(1'b0), .index_pulse_third_motor(1'b0),
		.range_sel(range_sel), .line_filt_sel(line_filt_sel), .pulse_filt_sel(pulse_filt_sel),
		.chan_func(chan_func), .pole_eff(pole_eff), .freq_src_eff(fsrc), .meas_value(meas_value),
		.mechanical_output(mech), .meas_done(meas_done));
	// ------------------------------
	// clock and access tasks
	// ------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe, so sample mid-cycle
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input string n);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		@(negedge ref_clk);
		chk(n, e & m, reg_rdata & m);
	endtask
	// boundary pulse, then room for the nine cycle scan
	task automatic tick();
		@(posedge ref_clk);
		update_tick <= 1'b1;
		@(posedge ref_clk);
		update_tick <= 1'b0;
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		fail_count++;
		close_out();
	end
	// ------------------------------
	// test sequence
	// ------------------------------
	initial
	begin
		{fail_count, compares, reg_wr, reg_rd, update_tick, lvl, pk} = '0;
		{reg_addr, reg_wdata} = '0;
		rst = 1'b1;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		wr(`MAS_A_CHSEL, 32'h0000_0000);
		rdc(`MAS_A_SCALE, 32'h0000_2710, '1, "scale");
		wr(`MAS_A_SCALE, 32'h0000_0000);
		rdc(`MAS_A_SCALE, 32'h0000_2710, '1, "scale");
		wr(`MAS_A_SCALE, 32'h0000_4E20);
		rdc(`MAS_A_SCALE, 32'h0000_4E20, '1, "scale");
		wr(`MAS_A_PULSEN, 32'h0000_2710);
		rdc(`MAS_A_PULSEN, 32'h0000_0001, '1, "pulsen");
		rdc(8'h7C, 32'h0000_0000, '1, "unmapped");
		wr(`MAS_A_UNITLO, 32'h4142_4301);
		rdc(`MAS_A_UNITLO, 32'h4142_4320, '1, "unit");
		wr(`MAS_A_POLE, 32'h0000_0304);
		wr(`MAS_A_CTRL, 32'h0000_0003);
		@(negedge ref_clk);
		chk("pole_aux", 32'h0000_0000, {25'h0, pole_eff});
		chk("fsrc_aux", 32'h0000_0000, {28'h0, fsrc});
		chk("func_aux", 32'h0000_0002, {30'h0, chan_func[1]});
		wr(`MAS_A_CTRL, 32'h0000_0000);
		@(negedge ref_clk);
		chk("pole", 32'h0000_0004, {25'h0, pole_eff});
		chk("fsrc", 32'h0000_0003, {28'h0, fsrc});
		chk("func_spd", 32'h0000_0001, {30'h0, chan_func[1]});
		for (int i = 0; i < 4; i++)
		begin
			wr(`MAS_A_CHCFG, (i << 7) | (i << 5));
			@(negedge ref_clk);
			chk("line", i, {30'h0, line_filt_sel[0]});
			chk("pnf", 32'h0000_0000, {30'h0, pulse_filt_sel[0]});
			wr(`MAS_A_CHCFG, (i << 7) | (i << 5) | 1);
			@(negedge ref_clk);
			chk("pnf", i, {30'h0, pulse_filt_sel[0]});
			chk("line", 32'h0000_0000, {30'h0, line_filt_sel[0]});
		end
		wr(`MAS_A_P1X, 32'h0000_0001);
		wr(`MAS_A_P1Y, 32'h0000_0005);
		wr(`MAS_A_P2X, 32'h0000_0003);
		wr(`MAS_A_P2Y, 32'h0000_0009);
		wr(`MAS_A_CALC, 32'h0000_0001);
		rdc(`MAS_A_SLOPE, 32'h0000_07D0, '1, "slope");
		rdc(`MAS_A_OFFSET, 32'h0000_0BB8, '1, "offset");
		wr(`MAS_A_P2X, 32'h0000_0001);
		wr(`MAS_A_CALC, 32'h0000_0001);
		rdc(`MAS_A_STATUS, 32'h0000_0010, 32'h0000_0010, "calc_err");
		rdc(`MAS_A_SLOPE, 32'h0000_07D0, '1, "slope");
		wr(`MAS_A_SLOPE, 32'h0000_0000);
		rdc(`MAS_A_SLOPE, 32'h0000_07D0, '1, "slope");
		wr(`MAS_A_CHCFG, 32'h0000_0002);
		@(posedge ref_clk);
		lvl <= 16'h1388;
		pk  <= 16'h1770;
		repeat (4) @(negedge ref_clk);
		chk("range", 32'h0000_0000, {29'h0, range_sel[0]});
		for (int i = 0; i < 5; i++)
		begin
			@(posedge ref_clk);
			lvl <= T_LVL[i];
			pk  <= T_PK[i];
			tick();
			chk("range", T_RNG[i], {29'h0, range_sel[0]});
		end
		wr(`MAS_A_SLOPE, 32'h0000_03E8);
		wr(`MAS_A_OFFSET, 32'h0000_01F4);
		wr(`MAS_A_CHCFG, 32'h0000_000C);
		tick();
		chk("range", 32'h0000_0003, {29'h0, range_sel[0]});
		chk("value", 32'h0000_2AF8, meas_value[0]);
		// speed 5.000 on ch1 times torque 11.000 on ch0, unit motor scale
		chk("mech", 32'((64'd55000000 * 64'(`MAS_TWO_PI_60)) >> `MAS_K_SHIFT), mech);
		close_out();
	end
endmodule
`default_nettype wire
